// File: logic/dme_params.svh
`ifndef DME_PARAMS_SVH
`define DME_PARAMS_SVH
// Functional notes
// - host debug command or breakpoint both enter debug
// - entry like interrupt but vectors to 8010h
// - fetch block, push, upa, ip, ige, halt
// - repeat entries in debug mode are ignored
// - timers frozen, no interrupt grant in debug
// - status 01b when ready for a command
// - engine runs only trace and return itself
// - command byte decides follow-on bytes and targets
// - no timeout; act only on full byte count
// - rom command sets cmd, rom, jump, busy
// - firmware sets txc, shift completion clears it
// - firmware sets rod, engine clears on recognition
// - undefined encodings and 0x20 do nothing
// - 0x21 needs no bytes, cmd 0001b
// - 0x22 takes address then count, cmd 0010b
// - 0x23 takes address then count, cmd 0011b
// - 0x27 returns to background and resumes cpu
// - status 00b outside debug, 01b inside while idle or collecting
// - streamed output bytes are tagged 11b

// ----------------------------------------
// register word offsets (avalon word address)
// ----------------------------------------
`define DME_OFF_CTRL 3'h0
`define DME_OFF_BUF 3'h1
`define DME_OFF_ADDR 3'h2
`define DME_OFF_DATA 3'h3
`define DME_OFF_SYSCTL 3'h4

// ----------------------------------------
// field positions
// ----------------------------------------
`define DME_CTRL_CMD_LSB 0
`define DME_CTRL_STAT_LSB 4
`define DME_CTRL_DBG_BIT 8
`define DME_SC_ROD_BIT 0
`define DME_SC_TXC_BIT 1

// ----------------------------------------
// reset values and fixed vector
// ----------------------------------------
`define DME_CMD_RESET 4'h0
`define DME_BUF_RESET 8'h00
`define DME_WORD_RESET 16'h0000
`define DME_ROM_ENTRY 16'h8010

// ----------------------------------------
// shift-word status codes
// ----------------------------------------
`define DME_ST_NONDEBUG 2'h0
`define DME_ST_IDLE 2'h1
`define DME_ST_BUSY 2'h2
`define DME_ST_VALID 2'h3

// ----------------------------------------
// host opcodes
// ----------------------------------------
`define DME_OP_DEBUG 8'h1f
`define DME_OP_NOP 8'h20
`define DME_OP_REGMAP 8'h21
`define DME_OP_RD_MEM 8'h22
`define DME_OP_RD_STACK 8'h23
`define DME_OP_WR_REG 8'h24
`define DME_OP_WR_MEM 8'h25
`define DME_OP_TRACE 8'h26
`define DME_OP_RETURN 8'h27
`define DME_OP_UNLOCK 8'h28
`define DME_OP_RD_REG 8'h29
`endif

// File: logic/dme_pkg.sv
package dme_pkg;
    // engine sequencing states
    typedef enum logic [3:0]
    {
        ST_BACK,
        ST_E_FETCH,
        ST_E_PUSH,
        ST_E_UPA,
        ST_E_IP,
        ST_E_IGE,
        ST_IDLE,
        ST_COLLECT,
        ST_BUSY,
        ST_STEP
    } dme_state_t;
endpackage

// File: logic/dme_shift_port.sv
`timescale 1ns/1ps
`include "dme_params.svh"
module dme_shift_port import dme_pkg::*; #(
    parameter int WORD_W = 10
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic tck_in,
    input wire logic tdi_in,
    input wire logic tap_shift_in,
    input wire logic tap_update_in,
    input wire logic tap_debug_sel_in,
    input wire logic tap_reset_in,
    input wire logic [1:0] status_in,
    input wire logic [7:0] tx_byte_in,
    output logic tdo_out,
    output logic [7:0] rx_byte_out,
    output logic rx_valid_out,
    output logic debug_sel_out,
    output logic tap_reset_out
);
    initial
    begin
        if (WORD_W != 10)
            $error("shift word must be 2 status bits plus one byte");
    end

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic tck_prev_reg;
    logic [WORD_W-1:0] shift_reg;

    // every pin crosses two flops; only stage two is read
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            tck_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= {tap_reset_in, tap_debug_sel_in, tap_update_in, tap_shift_in, tck_in};
            sync2_reg <= sync1_reg;
            tck_prev_reg <= sync2_reg[0];
        end
    end

    wire tck_rise = sync2_reg[0] & ~tck_prev_reg;
    wire tck_fall = ~sync2_reg[0] & tck_prev_reg;
    // tdi is sampled late enough that the second stage is settled at tck rise
    logic tdi_s1_reg;
    logic tdi_s2_reg;

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tdi_s1_reg <= 1'b0;
            tdi_s2_reg <= 1'b0;
        end
        else
        begin
            tdi_s1_reg <= tdi_in;
            tdi_s2_reg <= tdi_s1_reg;
        end
    end

    assign debug_sel_out = sync2_reg[3];
    assign tap_reset_out = sync2_reg[4];

    // ----------------------------------------
    // shift word, status in the two low bits
    // ----------------------------------------
    // a completed update hands the byte over and reloads status/buffer
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            shift_reg <= '0;
            rx_byte_out <= 8'h00;
            rx_valid_out <= 1'b0;
            tdo_out <= 1'b0;
        end
        else
        begin
            rx_valid_out <= 1'b0;
            if (tck_rise && sync2_reg[3] && sync2_reg[1])
                shift_reg <= {tdi_s2_reg, shift_reg[WORD_W-1:1]};
            else if (tck_rise && sync2_reg[3] && sync2_reg[2])
            begin
                rx_byte_out <= shift_reg[WORD_W-1:2];
                rx_valid_out <= 1'b1;
                shift_reg <= {tx_byte_in, status_in};
            end
            else if (!sync2_reg[1])
                shift_reg[1:0] <= status_in; // status stays current between words
            // between words the first status bit must already stand at the pin
            if (tck_fall || !sync2_reg[1])
                tdo_out <= shift_reg[0];
        end
    end
endmodule

// File: logic/dme_debug_engine.sv
`timescale 1ns/1ps
`include "dme_params.svh"
module dme_debug_engine import dme_pkg::*; (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic tck_in,
    input wire logic tdi_in,
    input wire logic tap_shift_in,
    input wire logic tap_update_in,
    input wire logic tap_debug_sel_in,
    input wire logic tap_reset_in,
    output logic tdo_out,
    input wire logic break_match_in,
    output logic fetch_block_out,
    output logic push_return_out,
    output logic upa_save_clear_out,
    output logic ip_load_out,
    output logic [15:0] ip_value_out,
    output logic ige_clear_out,
    output logic cpu_halt_out,
    output logic cpu_step_out,
    output logic cpu_resume_out,
    output logic rom_enable_out,
    output logic rom_jump_out,
    output logic timer_clk_en_out,
    output logic irq_grant_block_out,
    input wire logic [2:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);
    dme_state_t state_reg;
    logic [3:0] cmd_reg;
    logic [3:0] pend_cmd_reg;
    logic [2:0] need_reg;
    logic [2:0] idx_reg;
    logic [7:0] buf_reg;
    logic [15:0] addr_reg;
    logic [15:0] data_reg;
    logic txc_reg;
    logic rod_reg;
    logic ack_reg;
    logic [1:0] status;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic debug_sel;
    logic tap_rst;
    // bus strobes are declared early: the buffer and flag logic read them
    wire req = avs_read_in | avs_write_in;
    wire wr_fire = avs_write_in & ack_reg;

    // ----------------------------------------
    // tap side shift word
    // ----------------------------------------
    dme_shift_port #(.WORD_W(10)) u_port (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .tck_in(tck_in),
        .tdi_in(tdi_in),
        .tap_shift_in(tap_shift_in),
        .tap_update_in(tap_update_in),
        .tap_debug_sel_in(tap_debug_sel_in),
        .tap_reset_in(tap_reset_in),
        .status_in(status),
        .tx_byte_in(buf_reg),
        .tdo_out(tdo_out),
        .rx_byte_out(rx_byte),
        .rx_valid_out(rx_valid),
        .debug_sel_out(debug_sel),
        .tap_reset_out(tap_rst)
    );

    wire in_debug = (state_reg != ST_BACK);
    wire byte_ok = rx_valid & debug_sel & ~tap_rst;
    wire discard = ~debug_sel | tap_rst;

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    logic op_rom;
    logic [2:0] op_need;

    // only rom-assisted codes get here; trace/return are ours alone
    always_comb
    begin
        op_rom = 1'b1;
        op_need = 3'h0;
        unique case (rx_byte)
            `DME_OP_REGMAP: op_need = 3'h0;
            `DME_OP_RD_MEM: op_need = 3'h4;
            `DME_OP_RD_STACK: op_need = 3'h4;
            `DME_OP_WR_REG, `DME_OP_WR_MEM: op_need = 3'h4;
            `DME_OP_UNLOCK: op_need = 3'h0;
            `DME_OP_RD_REG: op_need = 3'h2;
            default: op_rom = 1'b0;
        endcase
    end

    wire launch_idle = (state_reg == ST_IDLE) && byte_ok && op_rom && (op_need == 3'h0);
    wire launch_coll = (state_reg == ST_COLLECT) && !discard && byte_ok && (idx_reg == need_reg - 3'h1);
    wire launch = launch_idle | launch_coll;

    // ----------------------------------------
    // engine sequencer
    // ----------------------------------------
    // entry steps run one per cycle in fixed order
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            state_reg <= ST_BACK;
        else
        begin
            unique case (state_reg)
                ST_BACK:
                    if (break_match_in || (byte_ok && rx_byte == `DME_OP_DEBUG))
                        state_reg <= ST_E_FETCH;
                ST_E_FETCH: state_reg <= ST_E_PUSH;
                ST_E_PUSH: state_reg <= ST_E_UPA;
                ST_E_UPA: state_reg <= ST_E_IP;
                ST_E_IP: state_reg <= ST_E_IGE;
                ST_E_IGE: state_reg <= ST_IDLE;
                ST_IDLE:
                    if (byte_ok)
                    begin
                        // debug command and breaks fall through as no-ops
                        if (launch_idle)
                            state_reg <= ST_BUSY;
                        else if (op_rom)
                            state_reg <= ST_COLLECT;
                        else if (rx_byte == `DME_OP_TRACE)
                            state_reg <= ST_STEP;
                        else if (rx_byte == `DME_OP_RETURN)
                            state_reg <= ST_BACK;
                    end
                ST_COLLECT:
                    if (discard)
                        state_reg <= ST_IDLE;
                    else if (launch_coll)
                        state_reg <= ST_BUSY;
                ST_BUSY:
                    if (rod_reg)
                        state_reg <= ST_IDLE;
                ST_STEP: state_reg <= ST_E_FETCH;
            endcase
        end
    end

    // ----------------------------------------
    // follow-on bytes, command field, buffers
    // ----------------------------------------
    // bytes arrive lsb first: address low/high, then data low/high
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pend_cmd_reg <= `DME_CMD_RESET;
            need_reg <= 3'h0;
            idx_reg <= 3'h0;
            cmd_reg <= `DME_CMD_RESET;
            addr_reg <= `DME_WORD_RESET;
            data_reg <= `DME_WORD_RESET;
        end
        else
        begin
            if (state_reg == ST_IDLE && byte_ok && op_rom)
            begin
                pend_cmd_reg <= rx_byte[3:0];
                need_reg <= op_need;
                idx_reg <= 3'h0;
            end
            else if (state_reg == ST_COLLECT && discard)
                idx_reg <= 3'h0;
            else if (state_reg == ST_COLLECT && byte_ok)
            begin
                idx_reg <= idx_reg + 3'h1;
                unique case (idx_reg)
                    3'h0: addr_reg[7:0] <= rx_byte;
                    3'h1: addr_reg[15:8] <= rx_byte;
                    3'h2: data_reg[7:0] <= rx_byte;
                    3'h3: data_reg[15:8] <= rx_byte;
                    default: idx_reg <= idx_reg;
                endcase
            end
            if (launch)
                cmd_reg <= launch_idle ? rx_byte[3:0] : pend_cmd_reg;
            if (wr_fire && avs_address_in == `DME_OFF_ADDR)
            begin
                if (avs_byteenable_in[0])
                    addr_reg[7:0] <= avs_writedata_in[7:0];
                if (avs_byteenable_in[1])
                    addr_reg[15:8] <= avs_writedata_in[15:8];
            end
            if (wr_fire && avs_address_in == `DME_OFF_DATA)
            begin
                if (avs_byteenable_in[0])
                    data_reg[7:0] <= avs_writedata_in[7:0];
                if (avs_byteenable_in[1])
                    data_reg[15:8] <= avs_writedata_in[15:8];
            end
        end
    end

    // buffer takes host bytes while busy (unlock data) and firmware output
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            buf_reg <= `DME_BUF_RESET;
        else if (wr_fire && avs_address_in == `DME_OFF_BUF && avs_byteenable_in[0])
            buf_reg <= avs_writedata_in[7:0];
        else if (state_reg == ST_BUSY && byte_ok)
            buf_reg <= rx_byte;
    end

    // ----------------------------------------
    // firmware handshake flags, set wins
    // ----------------------------------------
    wire sc_write = wr_fire && avs_address_in == `DME_OFF_SYSCTL && avs_byteenable_in[0];
    wire txc_set = sc_write && avs_writedata_in[`DME_SC_TXC_BIT];
    wire rod_set = sc_write && avs_writedata_in[`DME_SC_ROD_BIT];

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            txc_reg <= 1'b0;
            rod_reg <= 1'b0;
        end
        else
        begin
            if (txc_set)
                txc_reg <= 1'b1;
            else if (rx_valid)
                txc_reg <= 1'b0;
            if (rod_set)
                rod_reg <= 1'b1;
            else if (state_reg == ST_BUSY && rod_reg)
                rod_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // status code seen by the host
    // ----------------------------------------
    always_comb
    begin
        unique case (state_reg)
            ST_BACK: status = `DME_ST_NONDEBUG;
            ST_IDLE, ST_COLLECT: status = `DME_ST_IDLE;
            ST_BUSY: status = txc_reg ? `DME_ST_VALID : `DME_ST_BUSY;
            default: status = `DME_ST_BUSY;
        endcase
    end

    // ----------------------------------------
    // cpu side controls
    // ----------------------------------------
    assign fetch_block_out = (state_reg == ST_E_FETCH);
    assign push_return_out = (state_reg == ST_E_PUSH);
    assign upa_save_clear_out = (state_reg == ST_E_UPA);
    assign ip_load_out = (state_reg == ST_E_IP) | rom_jump_out;
    assign ip_value_out = `DME_ROM_ENTRY;
    assign ige_clear_out = (state_reg == ST_E_IGE);
    assign cpu_halt_out = (state_reg == ST_IDLE) | (state_reg == ST_COLLECT);
    assign cpu_step_out = (state_reg == ST_STEP);
    assign rom_enable_out = (state_reg == ST_BUSY);
    // freezing timers keeps user timing intact across the stop
    assign timer_clk_en_out = ~in_debug;
    assign irq_grant_block_out = in_debug;

    // jump and resume are single pulses
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rom_jump_out <= 1'b0;
            cpu_resume_out <= 1'b0;
        end
        else
        begin
            rom_jump_out <= launch;
            cpu_resume_out <= (state_reg == ST_IDLE) && byte_ok && rx_byte == `DME_OP_RETURN;
        end
    end

    // ----------------------------------------
    // avalon slave, one wait state
    // ----------------------------------------
    logic [31:0] rd_word;

    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (avs_address_in)
            `DME_OFF_CTRL:
            begin
                rd_word[`DME_CTRL_CMD_LSB +: 4] = cmd_reg;
                rd_word[`DME_CTRL_STAT_LSB +: 2] = status;
                rd_word[`DME_CTRL_DBG_BIT] = in_debug;
            end
            `DME_OFF_BUF: rd_word[7:0] = buf_reg;
            `DME_OFF_ADDR: rd_word[15:0] = addr_reg;
            `DME_OFF_DATA: rd_word[15:0] = data_reg;
            `DME_OFF_SYSCTL:
            begin
                rd_word[`DME_SC_ROD_BIT] = rod_reg;
                rd_word[`DME_SC_TXC_BIT] = txc_reg;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    assign avs_waitrequest_out = req & ~ack_reg;

    // read data is caught in the wait cycle and held for the answer edge
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ack_reg <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= req & ~ack_reg;
            if (avs_read_in && !ack_reg)
                avs_readdata_out <= rd_word;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    a_entry_order: assert property (fetch_block_out |=> push_return_out ##1 upa_save_clear_out
        ##1 (ip_load_out && ip_value_out == 16'h8010) ##1 ige_clear_out ##1 cpu_halt_out)
        else $error("entry sequence out of order");
    a_break_enters: assert property ((state_reg == ST_BACK && break_match_in) |=> fetch_block_out)
        else $error("breakpoint did not enter debug");
    a_debug_noop: assert property ((cpu_halt_out && byte_ok && rx_byte == `DME_OP_DEBUG) |=> cpu_halt_out)
        else $error("debug command disturbed debug mode");
    a_timer_frozen: assert property (in_debug |-> (!timer_clk_en_out && irq_grant_block_out))
        else $error("timers run in debug mode");
    a_status_idle: assert property ((state_reg == ST_IDLE) |-> status == 2'h1)
        else $error("idle status wrong");
    a_rom_launch: assert property (launch |=> (rom_jump_out && status[1] && cmd_reg == $past(
        launch_idle ? rx_byte[3:0] : pend_cmd_reg)))
        else $error("rom launch incomplete");
    a_txc_clear: assert property ((rx_valid && !txc_set) |=> !txc_reg)
        else $error("txc not cleared by shift");
    a_rod_clear: assert property ((state_reg == ST_BUSY && rod_reg && !rod_set) |=> (!rod_reg
        && state_reg == ST_IDLE))
        else $error("done bit not cleared");
    a_nop_none: assert property ((state_reg == ST_IDLE && byte_ok && rx_byte == `DME_OP_NOP)
        |=> state_reg == ST_IDLE)
        else $error("nop changed state");
    a_return_back: assert property ((state_reg == ST_IDLE && byte_ok && rx_byte == `DME_OP_RETURN)
        |=> (cpu_resume_out && status == 2'h0))
        else $error("return did not leave debug");
    a_valid_tag: assert property ((state_reg == ST_BUSY && txc_reg) |-> status == 2'h3)
        else $error("valid byte not tagged");
    a_discard: assert property ((state_reg == ST_COLLECT && discard) |=> (state_reg == ST_IDLE
        && idx_reg == 3'h0))
        else $error("partial command kept");

    c_enter_host: cover property (state_reg == ST_BACK && byte_ok && rx_byte == `DME_OP_DEBUG);
    c_four_bytes: cover property (launch_coll && need_reg == 3'h4);
    c_stream: cover property (state_reg == ST_BUSY && txc_reg ##[1:200] rx_valid);
    c_trace: cover property (cpu_step_out ##6 cpu_halt_out);
endmodule

// File: tb/dme_host_model.sv
`timescale 1ns/1ps
module dme_host_model (
    input wire logic clk_in,
    input wire logic tdo_in,
    output logic tck_out = 1'b0,
    output logic tdi_out = 1'b0,
    output logic shift_out = 1'b0,
    output logic update_out = 1'b0,
    output logic sel_out = 1'b1,
    output logic treset_out = 1'b0
);
    // ----
    // host side of the tap link
    // ----
    // tck idles low between frames, 8 system clocks per half period
    task automatic xfer(input logic [7:0] b, output logic [9:0] w);
        logic [9:0] v;
        v = {b, 2'b00};
        @(posedge clk_in);
        shift_out <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            tdi_out <= v[i];
            repeat (8) @(posedge clk_in);
            tck_out <= 1'b1;
            w[i] = tdo_in;
            repeat (8) @(posedge clk_in);
            tck_out <= 1'b0;
        end
        shift_out <= 1'b0;
        update_out <= 1'b1;
        tdi_out <= ~v[9]; // released line must not keep the last bit
        repeat (8) @(posedge clk_in);
        tck_out <= 1'b1;
        repeat (8) @(posedge clk_in);
        tck_out <= 1'b0;
        update_out <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask
    // way out of a garbled byte sequence: drop and reload the instruction
    task automatic reselect();
        @(posedge clk_in);
        sel_out <= 1'b0;
        repeat (16) @(posedge clk_in);
        sel_out <= 1'b1;
        repeat (8) @(posedge clk_in);
    endtask
endmodule

// File: tb/debug_mode_engine_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; $display("wrong value %0t %h %h", $time, a, b); end end
module debug_mode_engine_tb;
    logic clk_in, reset_n_in, tck_in, tdi_in, tap_shift_in, tap_update_in, tap_debug_sel_in, tap_reset_in, tdo_out;
    logic break_match_in, fetch_block_out, push_return_out, upa_save_clear_out, ip_load_out, ige_clear_out;
    logic cpu_halt_out, cpu_step_out, cpu_resume_out, rom_enable_out, rom_jump_out, timer_clk_en_out;
    logic irq_grant_block_out, avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [15:0] ip_value_out;
    logic [2:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, q;
    logic [3:0] avs_byteenable_in = 4'hf;
    logic [9:0] w;
    int num_errors, comparisons, cyc, nj, ns, nr, e;
    int t[5];
    dme_debug_engine DUT (.clk_in, .reset_n_in, .tck_in, .tdi_in, .tap_shift_in, .tap_update_in, .tap_debug_sel_in,
        .tap_reset_in, .tdo_out, .break_match_in, .fetch_block_out, .push_return_out, .upa_save_clear_out,
        .ip_load_out, .ip_value_out, .ige_clear_out, .cpu_halt_out, .cpu_step_out, .cpu_resume_out, .rom_enable_out,
        .rom_jump_out, .timer_clk_en_out, .irq_grant_block_out, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out);
    dme_host_model host (.clk_in, .tdo_in(tdo_out), .tck_out(tck_in), .tdi_out(tdi_in), .shift_out(tap_shift_in),
        .update_out(tap_update_in), .sel_out(tap_debug_sel_in), .treset_out(tap_reset_in));
    // ----
    // clock, pulse stamps, watchdog
    // ----
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // sampled mid-cycle so registered pulses have settled
    always @(negedge clk_in)
    begin
        cyc++;
        if (fetch_block_out) t[0] = cyc;
        if (push_return_out) t[1] = cyc;
        if (upa_save_clear_out) t[2] = cyc;
        if (ip_load_out) t[3] = cyc;
        if (ige_clear_out) t[4] = cyc;
        nj += rom_jump_out;
        ns += cpu_step_out;
        nr += cpu_resume_out;
        if (cyc == 20000)
        begin
            num_errors++;
            final_report();
        end
    end
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_in);
        avs_address_in <= a;
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        avs_writedata_in <= d;
        do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask
    task automatic st(input logic [1:0] s);
        bus(1'b0, 3'h0, 32'h0);
        `CHK(q[5:4], s)
    endtask
    task automatic brk();
        break_match_in <= 1'b1;
        @(posedge clk_in);
        break_match_in <= 1'b0;
    endtask
    task automatic wait_halt();
        for (int i = 0; i < 400 && cpu_halt_out !== 1'b1; i++) @(negedge clk_in);
        `CHK(cpu_halt_out, 1'b1)
    endtask
    task automatic final_report();
        if (num_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    initial
    begin
        reset_n_in = 1'b0;
        break_match_in = 1'b0;
        avs_address_in = 3'h0;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        `CHK(timer_clk_en_out, 1'b1)
        `CHK(ip_value_out, 16'h8010)
        st(2'h0);
        bus(1'b0, 3'h6, 32'h0);
        `CHK(q, 32'h0)
        brk();
        wait_halt();
        `CHK(t[0] < t[1] && t[1] < t[2] && t[2] < t[3] && t[3] < t[4], 1'b1)
        `CHK({timer_clk_en_out, irq_grant_block_out}, 2'b01)
        st(2'h1);
        // second entries, nop and an unused code must all be inert
        e = t[0];
        host.xfer(8'h1f, w);
        brk();
        host.xfer(8'h20, w);
        host.xfer(8'h3f, w);
        `CHK(t[0], e)
        st(2'h1);
        host.xfer(8'h22, w);
        host.xfer(8'h11, w);
        host.reselect();
        host.xfer(8'h21, w);
        bus(1'b0, 3'h0, 32'h0);
        `CHK(q[5:0], 6'h21)
        `CHK(rom_enable_out, 1'b1)
        bus(1'b1, 3'h4, 32'h1);
        st(2'h1);
        bus(1'b0, 3'h4, 32'h0);
        `CHK(q[0], 1'b0)
        for (int k = 2; k < 4; k++)
        begin
            host.xfer(8'h20 + k[7:0], w);
            host.xfer(8'h34, w);
            host.xfer(8'h12, w);
            host.xfer(8'h02, w);
            st(2'h1);
            host.xfer(8'h00, w);
            bus(1'b0, 3'h0, 32'h0);
            `CHK(q[5:0], {2'h2, k[3:0]})
            `CHK(nj, k)
            bus(1'b0, 3'h2, 32'h0);
            `CHK(q, 32'h1234)
            bus(1'b0, 3'h3, 32'h0);
            `CHK(q, 32'h0002)
            bus(1'b1, 3'h1, 32'ha5);
            bus(1'b1, 3'h4, 32'h2);
            st(2'h3);
            host.xfer(8'h00, w);
            `CHK(w[1:0], 2'h3)
            bus(1'b0, 3'h4, 32'h0);
            `CHK(q[1], 1'b0)
            bus(1'b1, 3'h4, 32'h1);
            st(2'h1);
        end
        e = t[0];
        host.xfer(8'h26, w);
        wait_halt();
        `CHK(ns == 1 && t[0] > e, 1'b1)
        st(2'h1);
        host.xfer(8'h27, w);
        `CHK({nr[1:0], cpu_halt_out, timer_clk_en_out}, 4'h5)
        st(2'h0);
        host.xfer(8'h1f, w);
        wait_halt();
        st(2'h1);
        final_report();
    end
endmodule
